// ==== abd_pkg.sv ====
// Package of constants for the auto-baud sync measurement block.
// Assumes one 20 MHz system clock shared by both ends of the serial link.
package abd_pkg;
  // Register byte offsets on the APB.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_DIV = 8'h08;
  localparam logic [7:0] OFF_RXBUF = 8'h0c;
  localparam logic [7:0] OFF_IRQ = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  // Control register fields.
  localparam int BIT_ENABLE = 0;
  localparam int BIT_WIDE = 1;
  localparam int BIT_HIGH = 2;
  localparam int BIT_WAKE = 3;
  localparam int BIT_OVF = 4;
  // Status register fields.
  localparam int BIT_RXFLAG = 0;
  localparam int BIT_IDLE = 1;
  // Interrupt status fields.
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVF = 1;
  // Measurement clock ratios in system clocks, and the base-to-measure factor.
  localparam logic [9:0] RATIO_SLOW = 10'h200;
  localparam logic [9:0] RATIO_MID = 10'h080;
  localparam logic [9:0] RATIO_FAST = 10'h020;
  localparam int BASE_SHIFT = 3;
  // Reset values.
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // Sync character, break length and frame length of the far transmitter.
  localparam logic [7:0] SYNC_CHAR = 8'h55;
  localparam logic [3:0] BREAK_BITS = 4'hd;
  localparam logic [3:0] FRAME_BITS = 4'ha;
  // Number of rising edges after the first that end the measurement.
  localparam logic [2:0] LAST_EDGE = 3'h4;
endpackage

// ==== abd_link_if.sv ====
// Interface carrying the serial receive line between the two ends.
// Assumes the transmitter drives the line high when idle.
`timescale 1ns/1ps
interface abd_link_if;
  logic rx_line;
  // Device end samples the line.
  modport dev (input rx_line);
  // Remote transmitter drives the line.
  modport xmt (output rx_line);
endinterface

// ==== abd_dev.sv ====
// Auto-baud measurement end: APB registers, divisor generator, sync timing.
// Assumes the receive line is asynchronous and the APB runs on SYS_CLK.
`timescale 1ns/1ps
module abd_dev (
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RST,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Serial link.
  abd_link_if.dev LINK,
  // Interrupt and baud rate outputs.
  output logic IRQ,
  output logic BAUD_TICK
);
  typedef enum {ST_OFF, ST_BRK_LOW, ST_BRK_HIGH, ST_START, ST_FIRST,
    ST_COUNT} abd_state_t;

  abd_state_t state_q, state_d;
  logic rx_s1_q, rx_s2_q, rx_s3_q, rx_q;
  logic enable_q, wide_q, high_q, wake_q, ovf_q, rxflag_q;
  logic [1:0] irq_q, mask_q;
  logic [15:0] div_q, div_d, baud_cnt_q;
  logic [9:0] pre_q;
  logic [2:0] edges_q;
  logic [31:0] prdata_q;
  logic tick_q;

  // Ratio of the prescaler: measurement clock, or base clock eight times
  // faster when the generator runs normally.
  function automatic logic [9:0] ratio(input logic wide, input logic high,
                                       input logic measure);
    logic [9:0] r;
    r = (wide & high) ? abd_pkg::RATIO_FAST :
        (wide | high) ? abd_pkg::RATIO_MID : abd_pkg::RATIO_SLOW;
    ratio = measure ? r : (r >> abd_pkg::BASE_SHIFT);
  endfunction

  // Bus decode and phases.
  wire setup = PSEL & ~PENABLE;
  wire access = PSEL & PENABLE;
  wire wr = access & PWRITE;
  wire rd = access & ~PWRITE;
  wire hit_ctrl = PADDR == abd_pkg::OFF_CTRL;
  wire hit_stat = PADDR == abd_pkg::OFF_STAT;
  wire hit_div = PADDR == abd_pkg::OFF_DIV;
  wire hit_rxbuf = PADDR == abd_pkg::OFF_RXBUF;
  wire hit_irq = PADDR == abd_pkg::OFF_IRQ;
  wire hit_mask = PADDR == abd_pkg::OFF_MASK;
  wire mapped = hit_ctrl | hit_stat | hit_div | hit_rxbuf | hit_irq | hit_mask;

  // Line edges after the input filter.
  wire rx_rise = (rx_s2_q == rx_s3_q) & rx_s3_q & ~rx_q;
  wire rx_fall = (rx_s2_q == rx_s3_q) & ~rx_s3_q & rx_q;

  // Measurement state and its events.
  wire measuring = state_q != ST_OFF;
  wire counting = state_q == ST_COUNT;
  wire [9:0] pre_lim = ratio(wide_q, high_q, counting) - 10'h001;
  wire pre_tick = pre_q == pre_lim;
  wire count_tick = counting & pre_tick;
  wire wrap = count_tick & (div_q == 16'hffff);
  // The first rise is taken in ST_FIRST, so edges_q holds one less than
  // the rises counted after it when the closing rise arrives.
  wire done = counting & rx_rise & (edges_q == abd_pkg::LAST_EDGE - 3'h1);
  wire start = wr & hit_ctrl & PWDATA[abd_pkg::BIT_ENABLE] & ~measuring;
  wire rx_read = rd & hit_rxbuf;

  // Answers on the bus: no wait states, error on unmapped offsets.
  assign PREADY = 1'b1;
  assign PSLVERR = access & ~mapped;
  assign PRDATA = prdata_q;
  assign IRQ = |(irq_q & mask_q);
  assign BAUD_TICK = tick_q;

  // Read data captured in the setup phase.
  wire [31:0] rd_mux =
    hit_ctrl ? {27'h0, ovf_q, wake_q, high_q, wide_q, enable_q} :
    hit_stat ? {30'h0, ~measuring, rxflag_q} :
    hit_div ? {16'h0, div_q} :
    hit_irq ? {30'h0, irq_q} :
    hit_mask ? {30'h0, mask_q} : abd_pkg::RD_ZERO;

  // Input filter: three flops, accept a level when the last two agree.
  always_ff @(posedge SYS_CLK) begin
    rx_s1_q <= LINK.rx_line;
    rx_s2_q <= rx_s1_q;
    rx_s3_q <= rx_s2_q;
    if (RST) begin
      rx_q <= 1'b1;
    end else if (rx_s2_q == rx_s3_q) begin
      rx_q <= rx_s3_q;
    end
  end

  // Measurement sequencer; the normal generator stays idle meanwhile.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (start) begin
          state_d = PWDATA[abd_pkg::BIT_WAKE] ? ST_BRK_LOW : ST_START;
        end
      end
      ST_BRK_LOW: if (rx_fall) state_d = ST_BRK_HIGH;
      ST_BRK_HIGH: if (rx_rise) state_d = ST_START;
      ST_START: if (rx_fall) state_d = ST_FIRST;
      ST_FIRST: if (rx_rise) state_d = ST_COUNT;
      ST_COUNT: if (done) state_d = ST_OFF;
      default: state_d = ST_OFF;
    endcase
  end

  // Divisor: loaded to one on the first rise, then a 16-bit counter.
  always_comb begin
    div_d = div_q;
    if (state_q == ST_FIRST && rx_rise) begin
      div_d = 16'h0001;
    end else if (count_tick) begin
      div_d = div_q + 16'h0001;
    end else if (wr && hit_div && !measuring) begin
      div_d = PWDATA[15:0];
    end
  end

  // Sequencer, divisor, prescaler and edge count.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_q <= ST_OFF;
      div_q <= abd_pkg::DIV_RESET;
      pre_q <= 10'h000;
      edges_q <= 3'h0;
    end else begin
      state_q <= state_d;
      div_q <= div_d;
      pre_q <= (pre_tick || (state_q == ST_FIRST && rx_rise)) ?
        10'h000 : pre_q + 10'h001;
      if (state_q == ST_FIRST) begin
        edges_q <= 3'h0;
      end else if (counting && rx_rise) begin
        edges_q <= edges_q + 3'h1;
      end
    end
  end

  // Normal generator: one tick every divisor plus one base clocks.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      baud_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (measuring) begin
        baud_cnt_q <= 16'h0000;
      end else if (pre_tick) begin
        tick_q <= baud_cnt_q == div_q;
        baud_cnt_q <= (baud_cnt_q == div_q) ? 16'h0000 :
          baud_cnt_q + 16'h0001;
      end
    end
  end

  // Control bits; hardware clears enable at the end, hardware set wins.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      enable_q <= 1'b0;
      wide_q <= 1'b0;
      high_q <= 1'b0;
      wake_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      if (wr && hit_ctrl) begin
        wide_q <= PWDATA[abd_pkg::BIT_WIDE];
        high_q <= PWDATA[abd_pkg::BIT_HIGH];
        wake_q <= PWDATA[abd_pkg::BIT_WAKE];
        if (!PWDATA[abd_pkg::BIT_OVF]) begin
          ovf_q <= 1'b0;
        end
      end
      if (start) begin
        enable_q <= 1'b1;
      end else if (done) begin
        enable_q <= 1'b0;
      end
      if (wrap) begin
        ovf_q <= 1'b1;
      end
    end
  end

  // Receive flag: set at the end or on overflow, cleared by a buffer read.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rxflag_q <= 1'b0;
    end else if (done || wrap) begin
      rxflag_q <= 1'b1;
    end else if (rx_read) begin
      rxflag_q <= 1'b0;
    end
  end

  // Sticky interrupt status cleared by its read, mask, and read data.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      irq_q <= 2'b00;
      mask_q <= 2'b00;
      prdata_q <= abd_pkg::RD_ZERO;
    end else begin
      irq_q <= ((rd && hit_irq) ? 2'b00 : irq_q) | {wrap, done};
      if (wr && hit_mask) begin
        mask_q <= PWDATA[1:0];
      end
      if (setup) begin
        prdata_q <= rd_mux;
      end
    end
  end
endmodule

// ==== abd_xmt.sv ====
// Remote transmitter end: sends an optional break, then the sync character.
// Assumes the bit period is given in system clocks and held during a frame.
`timescale 1ns/1ps
module abd_xmt (
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RST,
  // User side.
  input wire logic SEND,
  input wire logic WITH_BREAK,
  input wire logic [15:0] BIT_CYCLES,
  output logic BUSY,
  // Serial link.
  abd_link_if.xmt LINK
);
  typedef enum {XS_IDLE, XS_BREAK, XS_DELIM, XS_FRAME} abd_xstate_t;

  abd_xstate_t state_q;
  logic [15:0] cyc_q;
  logic [3:0] bit_q;
  logic [9:0] shift_q;
  logic line_q;

  wire bit_end = cyc_q == (BIT_CYCLES - 16'h0001);

  assign BUSY = state_q != XS_IDLE;
  assign LINK.rx_line = line_q;

  // Frame sequencer: break low, one delimiter bit high, then start,
  // data least significant first and stop.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_q <= XS_IDLE;
      cyc_q <= 16'h0000;
      bit_q <= 4'h0;
      shift_q <= 10'h3ff;
      line_q <= 1'b1;
    end else begin
      cyc_q <= (state_q == XS_IDLE || bit_end) ? 16'h0000 : cyc_q + 16'h0001;
      case (state_q)
        XS_IDLE: begin
          bit_q <= 4'h0;
          shift_q <= {1'b1, abd_pkg::SYNC_CHAR, 1'b0};
          if (SEND) begin
            state_q <= WITH_BREAK ? XS_BREAK : XS_FRAME;
            line_q <= 1'b0;
          end
        end
        XS_BREAK: begin
          if (bit_end) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == abd_pkg::BREAK_BITS - 4'h1) begin
              bit_q <= 4'h0;
              line_q <= 1'b1;
              state_q <= XS_DELIM;
            end
          end
        end
        XS_DELIM: begin
          if (bit_end) begin
            line_q <= 1'b0;
            state_q <= XS_FRAME;
          end
        end
        XS_FRAME: begin
          if (bit_end) begin
            bit_q <= bit_q + 4'h1;
            shift_q <= {1'b1, shift_q[9:1]};
            line_q <= shift_q[1];
            if (bit_q == abd_pkg::FRAME_BITS - 4'h1) begin
              line_q <= 1'b1;
              state_q <= XS_IDLE;
            end
          end
        end
        default: state_q <= XS_IDLE;
      endcase
    end
  end
endmodule

// ==== abd_props.sv ====
// Checker of the serial line and the APB answers of the auto-baud block.
// Assumes the bench keeps every bit period at eight cycles or more.
`timescale 1ns/1ps
module abd_props (
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RST,
  // Link and transmitter user side.
  input wire logic rx_line,
  input wire logic SEND,
  input wire logic BUSY,
  // APB and interrupt.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [7:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic IRQ
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  // A frame request taken while idle.
  sequence s_take;
    SEND && !BUSY;
  endsequence
  // The start bit that follows it.
  sequence s_start;
    !rx_line && BUSY;
  endsequence
  a_start_bit: assert property (
    s_take |=> s_start ##1 (!rx_line [*7]))
    else $error("Start bit not sent after request");
  a_idle_high: assert property (!BUSY |-> rx_line)
    else $error("Line low while transmitter idle");
  a_stop_high: assert property ($fell(BUSY) |-> rx_line)
    else $error("Frame ended without stop level");
  a_busy_cause: assert property ($rose(BUSY) |-> $past(SEND))
    else $error("Transmitter busy without request");
  a_err_unmapped: assert property (
    PSEL && PENABLE && PADDR > abd_pkg::OFF_MASK |-> PSLVERR)
    else $error("No error on unmapped access");
  a_err_mapped: assert property (
    PSEL && PENABLE && PADDR == abd_pkg::OFF_RXBUF |-> !PSLVERR)
    else $error("Error on mapped access");
  a_err_access: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("Error outside access phase");
  a_ready_high: assert property (PSEL && PENABLE |-> PREADY)
    else $error("Ready low in access phase");
  a_irq_fall: assert property (
    $fell(IRQ) |-> $past(PSEL && PENABLE))
    else $error("Interrupt fell outside a bus access");
  cover property (s_take ##1 s_start);
endmodule

// ==== uart_auto_baud_detect_tb_top.sv ====
// Bench of the auto-baud block with both ends joined over the link.
// Assumes a zero-wait APB slave and a sync byte from the remote end.
`timescale 1ns/1ps
module uart_auto_baud_detect_tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic baud_tick;
  logic send = 1'b0;
  logic with_break = 1'b0;
  // Bit period kept inside every selected measuring range.
  logic [15:0] bit_cycles = 16'h0042;
  logic busy;
  logic [31:0] rd;
  logic [15:0] exp_div [4] = '{16'h0002, 16'h0005, 16'h0005, 16'h0011};
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int gap;
  abd_link_if link ();
  abd_dev i_abd_dev (.SYS_CLK(sys_clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(link),
    .IRQ(irq), .BAUD_TICK(baud_tick));
  abd_xmt i_abd_xmt (.SYS_CLK(sys_clk), .RST(rst), .SEND(send),
    .WITH_BREAK(with_break), .BIT_CYCLES(bit_cycles), .BUSY(busy),
    .LINK(link));
  abd_props i_abd_props (.SYS_CLK(sys_clk), .RST(rst),
    .rx_line(link.rx_line), .SEND(send), .BUSY(busy), .PSEL(psel),
    .PENABLE(penable), .PADDR(paddr), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq));
  // Clock of 50 ns period.
  always #25 sys_clk = ~sys_clk;
  // Cuts a hung run short.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      complete_run();
    end
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, entered just after a rising edge.
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Sends one frame and waits until the transmitter is idle again.
  task automatic send_frame(input logic brk);
    with_break <= brk;
    send <= 1'b1;
    @(posedge sys_clk);
    send <= 1'b0;
    repeat (2) @(posedge sys_clk);
    while (busy !== 1'b0) @(posedge sys_clk);
    repeat (8) @(posedge sys_clk);
  endtask
  // One whole calibration with its status checks.
  task automatic measure(input logic [31:0] ctrl, input logic brk,
    input logic [15:0] div);
    apb(1'b1, abd_pkg::OFF_CTRL, ctrl, rd);
    apb(1'b0, abd_pkg::OFF_STAT, 32'h0, rd);
    check(rd, 32'h0);
    apb(1'b1, abd_pkg::OFF_DIV, 32'h1234, rd);
    send_frame(brk);
    apb(1'b0, abd_pkg::OFF_DIV, 32'h0, rd);
    check(rd, {16'h0, div});
    check({24'h0, rd[15:8]}, 32'h0);
    apb(1'b0, abd_pkg::OFF_CTRL, 32'h0, rd);
    check(rd, ctrl & 32'hffff_fffe);
    apb(1'b0, abd_pkg::OFF_STAT, 32'h0, rd);
    check(rd, 32'h3);
    apb(1'b0, abd_pkg::OFF_RXBUF, 32'h0, rd);
    apb(1'b0, abd_pkg::OFF_STAT, 32'h0, rd);
    check(rd, 32'h2);
  endtask
  // Main sequence of tests.
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    apb(1'b0, abd_pkg::OFF_DIV, 32'h0, rd);
    check(rd, {16'h0, abd_pkg::DIV_RESET});
    apb(1'b0, 8'h18, 32'h0, rd);
    check(rd, abd_pkg::RD_ZERO);
    $display("Test reset values done");
    apb(1'b1, abd_pkg::OFF_MASK, 32'h0, rd);
    measure(32'h7, 1'b0, 16'h0011);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, abd_pkg::OFF_MASK, 32'h1, rd);
    check({31'h0, irq}, 32'h1);
    apb(1'b0, abd_pkg::OFF_IRQ, 32'h0, rd);
    check(rd, 32'h1 << abd_pkg::IRQ_DONE);
    check({31'h0, irq}, 32'h0);
    $display("Test calibration and interrupt done");
    while (baud_tick !== 1'b1) @(negedge sys_clk);
    gap = 0;
    do begin
      gap++;
      @(negedge sys_clk);
    end while (baud_tick !== 1'b1);
    check(gap, 32'd72);
    @(posedge sys_clk);
    $display("Test divisor use done");
    for (int m = 0; m < 4; m++) begin
      measure({29'h0, m[1], m[0], 1'b1}, 1'b0, exp_div[m]);
    end
    $display("Test clock selects done");
    measure(32'hf, 1'b1, 16'h0011);
    $display("Test break then sync done");
    complete_run();
  end
endmodule
